// file: hw/tmr2_timer.v
// 16-bit timer/counter with capture, auto-reload, baud generator and clock-out.
// Assumes an APB master on pclk; count and trigger pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "tmr2_consts.vh"

module tmr2_timer (
	input wire pclk, // System clock, 40 MHz
	input wire presetn, // Asynchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error for unmapped address
	input wire count_in, // External count input pin
	input wire ext_trigger_pin, // External trigger / direction pin
	output reg clock_out_pin, // Clock-out square wave
	output reg clock_out_oe_n, // Clock-out drive enable, low drives
	output reg rx_baud_tick, // Receive baud overflow pulse
	output reg tx_baud_tick, // Transmit baud overflow pulse
	output reg irq // Level interrupt
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] timer_two_control;
	reg [7:0] timer_two_mode;
	reg [15:0] count;
	reg [15:0] capture;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg [3:0] prescale;
	reg [2:0] cnt_sync;
	reg [2:0] trg_sync;
	reg next_irq;

	wire overflow_flag = timer_two_control[`TMR2_CTL_OVF_FLAG];
	wire external_event_flag = timer_two_control[`TMR2_CTL_EXT_FLAG];
	wire rx_clock_select = timer_two_control[`TMR2_CTL_RX_CLK];
	wire tx_clock_select = timer_two_control[`TMR2_CTL_TX_CLK];
	wire ext_trigger_enable = timer_two_control[`TMR2_CTL_EXT_EN];
	wire run_control = timer_two_control[`TMR2_CTL_RUN];
	wire counter_select = timer_two_control[`TMR2_CTL_COUNTER_SEL];
	wire capture_reload_select = timer_two_control[`TMR2_CTL_CAPTURE_SEL];
	wire down_count_enable = timer_two_mode[`TMR2_MOD_DOWN_EN];
	wire clock_out_enable = timer_two_mode[`TMR2_MOD_CLKOUT_EN];

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire baud_mode = run_control & (rx_clock_select | tx_clock_select);
	wire clkout_mode = run_control & ~capture_reload_select & clock_out_enable
		& ~counter_select;
	wire capture_mode = run_control & ~baud_mode & capture_reload_select;
	wire reload_mode = run_control & ~baud_mode & ~capture_reload_select;
	wire fast_clock = baud_mode | clkout_mode;
	wire roll_quiet = baud_mode | clkout_mode;

	// Synchronisers; only stages 1 and 2 feed logic
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_sync <= 3'b111;
			trg_sync <= 3'b111;
		end else begin
			cnt_sync <= {cnt_sync[1:0], count_in};
			trg_sync <= {trg_sync[1:0], ext_trigger_pin};
		end
	end

	wire trg_level = trg_sync[1];
	wire trg_fall = trg_sync[2] & ~trg_sync[1];
	wire cnt_fall = cnt_sync[2] & ~cnt_sync[1];
	wire ext_event = ext_trigger_enable & trg_fall;

	// ----------------------------------------
	// Count tick
	// ----------------------------------------
	wire [3:0] pre_limit = fast_clock ? `TMR2_PRESCALE_FAST : `TMR2_PRESCALE_TIMER;
	wire pre_done = (prescale >= pre_limit - 4'h1);
	wire use_events = counter_select & ~clkout_mode;
	wire tick = run_control & (use_events ? cnt_fall : pre_done);

	// Prescaler for timer function
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= 4'h0;
		end else if (!run_control || pre_done) begin
			prescale <= 4'h0;
		end else begin
			prescale <= prescale + 4'h1;
		end
	end

	// ----------------------------------------
	// Counter events
	// ----------------------------------------
	wire counting_down = reload_mode & ~fast_clock & down_count_enable & ~trg_level;
	wire at_top = (count == `TMR2_COUNT_TOP);
	wire up_roll = tick & ~counting_down & at_top;
	wire down_roll = tick & counting_down & (count == capture);
	wire roll = up_roll | down_roll;
	wire updown = reload_mode & ~fast_clock & down_count_enable;
	wire cap_event = capture_mode & ext_event;
	wire ext_reload = reload_mode & ~fast_clock & ~down_count_enable & ext_event;
	wire ext_set = cap_event | ext_reload | (baud_mode & ext_event);
	wire ovf_set = roll & ~roll_quiet;
	wire ext_toggle = updown & roll;

	// APB decode
	wire wr = psel & penable & pwrite & pready;
	wire wr_ctl = wr & (paddr == `TMR2_ADDR_CONTROL);
	wire wr_mod = wr & (paddr == `TMR2_ADDR_MODE);
	wire wr_cnt = wr & (paddr == `TMR2_ADDR_COUNT);
	wire wr_cap = wr & (paddr == `TMR2_ADDR_CAPTURE);
	wire wr_sts = wr & (paddr == `TMR2_ADDR_IRQ_STATUS);
	wire wr_msk = wr & (paddr == `TMR2_ADDR_IRQ_MASK);
	wire mapped = (paddr == `TMR2_ADDR_CONTROL) | (paddr == `TMR2_ADDR_MODE)
		| (paddr == `TMR2_ADDR_COUNT) | (paddr == `TMR2_ADDR_CAPTURE)
		| (paddr == `TMR2_ADDR_IRQ_STATUS) | (paddr == `TMR2_ADDR_IRQ_MASK);

	// Count register: software load, reloads and stepping
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= `TMR2_RST_WORD;
		end else if (up_roll && !capture_mode) begin
			count <= capture;
		end else if (down_roll) begin
			count <= `TMR2_COUNT_TOP;
		end else if (ext_reload) begin
			count <= capture;
		end else if (tick) begin
			count <= counting_down ? count - 16'h0001 : count + 16'h0001;
		end else if (wr_cnt) begin
			count <= pwdata[15:0];
		end
	end

	// Capture register pair
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture <= `TMR2_RST_WORD;
		end else if (cap_event) begin
			capture <= tick ? (at_top ? 16'h0000 : count + 16'h0001) : count;
		end else if (wr_cap) begin
			capture <= pwdata[15:0];
		end
	end

	// Control register; hardware set wins over software clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_two_control <= `TMR2_RST_CONTROL;
		end else begin
			if (wr_ctl) begin
				timer_two_control <= pwdata[7:0];
			end
			if (ovf_set) begin
				timer_two_control[`TMR2_CTL_OVF_FLAG] <= 1'b1;
			end
			if (ext_set) begin
				timer_two_control[`TMR2_CTL_EXT_FLAG] <= 1'b1;
			end else if (ext_toggle) begin
				timer_two_control[`TMR2_CTL_EXT_FLAG] <= ~external_event_flag;
			end
		end
	end

	// Mode register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_two_mode <= `TMR2_RST_MODE;
		end else if (wr_mod) begin
			timer_two_mode <= {6'b00_0000, pwdata[1:0]};
		end
	end

	// ----------------------------------------
	// Interrupt status, mask and output
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 2'b00;
			irq_mask <= 2'b00;
			irq <= 1'b0;
		end else begin
			irq_status[`TMR2_IRQ_OVF] <= ovf_set | (irq_status[`TMR2_IRQ_OVF]
				& ~(wr_sts & pwdata[`TMR2_IRQ_OVF]));
			irq_status[`TMR2_IRQ_EXT] <= (ext_set & ~updown) | (irq_status[`TMR2_IRQ_EXT]
				& ~(wr_sts & pwdata[`TMR2_IRQ_EXT]));
			if (wr_msk) begin
				irq_mask <= pwdata[1:0];
			end
			irq <= next_irq;
		end
	end

	// Interrupt level from unmasked status
	always @* begin
		next_irq = |(irq_status & irq_mask);
	end

	// ----------------------------------------
	// Baud ticks and clock-out
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_baud_tick <= 1'b0;
			tx_baud_tick <= 1'b0;
			clock_out_pin <= 1'b1;
			clock_out_oe_n <= 1'b1;
		end else begin
			rx_baud_tick <= baud_mode & rx_clock_select & up_roll;
			tx_baud_tick <= baud_mode & tx_clock_select & up_roll;
			clock_out_oe_n <= ~clkout_mode;
			if (clkout_mode && up_roll) begin
				clock_out_pin <= ~clock_out_pin;
			end
		end
	end

	// ----------------------------------------
	// APB slave: one wait state, error on unmapped
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= 32'h0000_0000;
			if (psel && penable && !pready && !pwrite) begin
				case (paddr)
					`TMR2_ADDR_CONTROL: prdata <= {24'h00_0000, timer_two_control};
					`TMR2_ADDR_MODE: prdata <= {24'h00_0000, timer_two_mode};
					`TMR2_ADDR_COUNT: prdata <= {16'h0000, count};
					`TMR2_ADDR_CAPTURE: prdata <= {16'h0000, capture};
					`TMR2_ADDR_IRQ_STATUS: prdata <= {30'h0000_0000, irq_status};
					`TMR2_ADDR_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // tmr2_timer
`default_nettype wire

// file: hw/tmr2_consts.vh
// Constants for the 16-bit capture / reload / clock-out timer block.
// Assumes inclusion by bare name from the design file; definitions only.
//
// Contract
// - 16-bit up/down counter, timer or event counter chosen by counter_select.
// - Mode: off, else baud, else capture, else reload; clock-out beside baud or reload.
// - run_control (control bit 2) starts and stops counting, clock-out too.
// - Capture mode sets overflow_flag on every 16-bit overflow.
// - Capture mode, trigger enabled: falling edge copies count to capture, sets flag.
// - Both flags may interrupt; software clears them, and down-enabled rolls toggle the external flag.
// - down_count_enable resets to zero, so reload counts up.
// - Up reload: overflow past 0xFFFF sets flag, loads capture value.
// - Up reload with trigger enabled: falling edge reloads, sets external flag.
// - Down enabled, trigger high: count up, overflow sets flag, reloads capture.
// - Down enabled, trigger low: count down, at capture value reload 0xFFFF.
// - Down enabled: external flag toggles each roll, requests no interrupt.
// - Either clock select enters baud mode; overflows clock that direction.
// - Clock-out needs counter_select and capture_reload_select clear, clock_out_enable and run set.
// - Clock-out frequency is clock over 4 times (65536 minus capture).
// - Roll-overs in clock-out or baud mode raise no interrupt.
// - Baud and clock-out may run together from one reload value.
`ifndef TMR2_CONSTS_VH
`define TMR2_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TMR2_ADDR_CONTROL 8'hc8
`define TMR2_ADDR_MODE 8'hcc
`define TMR2_ADDR_COUNT 8'hd0
`define TMR2_ADDR_CAPTURE 8'hd4
`define TMR2_ADDR_IRQ_STATUS 8'hd8
`define TMR2_ADDR_IRQ_MASK 8'hdc

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TMR2_CTL_CAPTURE_SEL 0
`define TMR2_CTL_COUNTER_SEL 1
`define TMR2_CTL_RUN 2
`define TMR2_CTL_EXT_EN 3
`define TMR2_CTL_TX_CLK 4
`define TMR2_CTL_RX_CLK 5
`define TMR2_CTL_EXT_FLAG 6
`define TMR2_CTL_OVF_FLAG 7

// Mode register fields
`define TMR2_MOD_DOWN_EN 0
`define TMR2_MOD_CLKOUT_EN 1

// Interrupt status and mask fields
`define TMR2_IRQ_OVF 0
`define TMR2_IRQ_EXT 1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define TMR2_RST_CONTROL 8'h00
`define TMR2_RST_MODE 8'h00
`define TMR2_RST_WORD 16'h0000
`define TMR2_COUNT_TOP 16'hffff
`define TMR2_PRESCALE_TIMER 4'hc
`define TMR2_PRESCALE_FAST 4'h2

`endif

// file: tb/tmr2_timer_monitor.sv
// Checker on the timer block's bus answer and pin outputs.
// Assumes the top module tmr2_timer; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module tmr2_timer_monitor (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic clock_out_pin, // Square wave
	input wire logic rx_baud_tick, // Receive tick
	input wire logic tx_baud_tick // Transmit tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Bus answer and pin timing
	// ----------------------------------------
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	ready_cause_a: assert property (pready |-> $past(psel) && $past(penable)) else $error("ready unasked");
	answer_time_a: assert property (psel && $rose(penable) |=> pready) else $error("answer late");
	err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error reply");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper bits set");
	rx_tick_a: assert property (rx_baud_tick |=> !rx_baud_tick) else $error("rx tick wide");
	tx_tick_a: assert property (tx_baud_tick |=> !tx_baud_tick) else $error("tx tick wide");
	clk_half_a: assert property ($changed(clock_out_pin) |=> $stable(clock_out_pin)) else $error("wave short");
endmodule // tmr2_timer_monitor
bind tmr2_timer tmr2_timer_monitor u_tmr2_timer_monitor (.pclk, .presetn, .psel, .penable, .prdata, .pready,
	.pslverr, .clock_out_pin, .rx_baud_tick, .tx_baud_tick);
`default_nettype wire

// file: tb/tmr2_pins.sv
// Model of the count and trigger pins outside the timer block.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tmr2_pins (
	input wire logic pclk, // Clock
	output logic count_in = 1'h1, // Event pin, idles high
	output logic ext_trigger_pin = 1'h1 // Trigger pin, idles high
);
	// Falling edges held long enough to pass the synchroniser
	task count(input int n);
		repeat (n) begin
			count_in <= 1'h0;
			repeat (4) @(posedge pclk);
			count_in <= 1'h1;
			repeat (4) @(posedge pclk);
		end
	endtask
	// Trigger level, then settle time
	task trig(input logic v);
		ext_trigger_pin <= v;
		repeat (8) @(posedge pclk);
	endtask
endmodule // tmr2_pins
`default_nettype wire

// file: tb/tmr2_timer_bench.sv
// Self-checking bench for the timer block over its register bus.
// Assumes the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tmr2_timer_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, count_in, ext_trigger_pin, clock_out_pin, clock_out_oe_n, rx_baud_tick, tx_baud_tick, irq;
	int errors = 0, compares = 0;
	always #12.5 pclk = ~pclk;
	tmr2_timer u_tmr2_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .count_in, .ext_trigger_pin, .clock_out_pin, .clock_out_oe_n, .rx_baud_tick, .tx_baud_tick, .irq);
	tmr2_pins u_tmr2_pins (.pclk, .count_in, .ext_trigger_pin);
	// ----------------------------------------
	// Compare, bus transfer, verdict
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (!pready && ++n < 20);
		if (n == 20) begin
			errors++;
			report_and_stop;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	// Cycles between two clock-out toggles, or two cycles with transmit and receive ticks together
	task gap(input logic tx, input int want);
		int k, at[$];
		logic last, ev;
		last = clock_out_pin;
		for (k = 0; k < 100 && at.size() < 2; k++) begin
			@(posedge pclk);
			ev = tx ? (tx_baud_tick && rx_baud_tick) : clock_out_pin !== last;
			last = clock_out_pin;
			if (ev) at.push_back(k);
		end
		check(at.size() == 2 ? at[1] - at[0] : 0, want);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		rchk(8'hc8, 32'h0000_0000);
		rchk(8'hcc, 32'h0000_0000);
		xfer(0, 8'he0, 32'h0000_0000);
		check(err, 32'h0000_0001);
		$display("reset test done");
		xfer(1, 8'hd0, 32'h0000_1234);
		xfer(1, 8'hc8, 32'h0000_000f);
		u_tmr2_pins.trig(0);
		u_tmr2_pins.trig(1);
		rchk(8'hd4, 32'h0000_1234);
		rchk(8'hc8, 32'h0000_004f);
		xfer(1, 8'hdc, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		check(irq, 32'h0000_0001);
		xfer(1, 8'hd8, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		check(irq, 32'h0000_0000);
		xfer(1, 8'hd0, 32'h0000_ffff);
		u_tmr2_pins.count(1);
		rchk(8'hd0, 32'h0000_0000);
		rchk(8'hc8, 32'h0000_00cf);
		$display("capture test done");
		xfer(1, 8'hc8, 32'h0000_0000);
		xfer(1, 8'hd0, 32'h0000_fffe);
		xfer(1, 8'hd4, 32'h0000_fff0);
		xfer(1, 8'hc8, 32'h0000_0006);
		u_tmr2_pins.count(3);
		rchk(8'hd0, 32'h0000_fff1);
		rchk(8'hc8, 32'h0000_0086);
		xfer(1, 8'hc8, 32'h0000_0006);
		xfer(1, 8'hcc, 32'h0000_0001);
		xfer(1, 8'hd0, 32'h0000_ffff);
		u_tmr2_pins.count(1);
		rchk(8'hd0, 32'h0000_fff0);
		rchk(8'hc8, 32'h0000_00c6);
		$display("reload test done");
		xfer(1, 8'hc8, 32'h0000_0000);
		xfer(1, 8'hd8, 32'h0000_0003);
		xfer(1, 8'hcc, 32'h0000_0002);
		xfer(1, 8'hd4, 32'h0000_fffe);
		xfer(1, 8'hc8, 32'h0000_0034);
		gap(1, 4);
		gap(0, 4);
		check(clock_out_oe_n, 32'h0000_0000);
		rchk(8'hc8, 32'h0000_0034);
		rchk(8'hd8, 32'h0000_0000);
		$display("clock-out test done");
		report_and_stop;
	end
endmodule // tmr2_timer_bench
`default_nettype wire
